//--- include/abu_pkg.sv
// Constants and types shared by the address breakpoint unit.
package abu_pkg;

  localparam logic [4:0] ABU_OFS_STATUS_CONTROL = 5'h00;
  localparam logic [4:0] ABU_OFS_ADDRESS_HIGH = 5'h04;
  localparam logic [4:0] ABU_OFS_ADDRESS_LOW = 5'h08;
  localparam logic [4:0] ABU_OFS_WAIT_EXIT_STATUS = 5'h0c;
  localparam logic [4:0] ABU_OFS_FLAG_CLEAR_CONTROL = 5'h10;
  localparam logic [4:0] ABU_OFS_IRQ_STATUS = 5'h14;
  localparam logic [4:0] ABU_OFS_IRQ_MASK = 5'h18;

  localparam int ABU_BIT_BRK_ENABLE = 7;
  localparam int ABU_BIT_BREAK_ACTIVE = 6;
  localparam int ABU_BIT_WAIT_EXIT = 1;
  localparam int ABU_BIT_FLAG_CLEAR = 7;
  localparam int ABU_IRQ_BREAK_ENTRY = 0;
  localparam int ABU_IRQ_WAIT_EXIT = 1;
  localparam int ABU_IRQ_WIDTH = 2;

  localparam logic [7:0] ABU_RST_BYTE = 8'h00;
  localparam logic [15:0] ABU_VECTOR_NORMAL = 16'hfffc;
  localparam logic [15:0] ABU_VECTOR_MONITOR = 16'hfefc;

  typedef enum logic [1:0] {
    ABU_IDLE,
    ABU_PENDING,
    ABU_ACTIVE
  } abu_fsm_t;

  typedef struct packed {
    abu_fsm_t fsm;
    logic brk_enable_bit;
    logic break_active_bit;
    logic [7:0] break_address_high;
    logic [7:0] break_address_low;
    logic rearm_block;
    logic flag_clear_in_break_enable;
    logic wait_exit_by_break_flag;
    logic [ABU_IRQ_WIDTH-1:0] irq_status;
    logic [ABU_IRQ_WIDTH-1:0] irq_mask;
    logic tv_s1;
    logic tv_s2;
    logic tv_s3;
    logic tv_level;
    logic ap_valid;
    logic ap_write;
    logic [4:0] ap_addr;
    logic [31:0] rdata;
    logic inject;
    logic [15:0] vector;
  } abu_state_t;

endpackage : abu_pkg

//--- logic/abu_address_breakpoint_unit.sv
// Address breakpoint unit with an AHB-Lite register slave.
//
// Design decisions made here: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps

module abu_address_breakpoint_unit #(
  parameter logic [7:0] SOFTWARE_INTERRUPT_OPCODE = 8'h00
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [15:0] cpu_addr,
  input wire logic cpu_pc_fetch,
  input wire logic cpu_opcode_fetch,
  input wire logic cpu_instr_boundary,
  input wire logic cpu_rti_done,
  input wire logic low_power_mode,
  input wire logic wait_mode,
  input wire logic monitor_mode,
  input wire logic emulation_mode,
  input wire logic test_voltage_level,
  output logic breakpoint_request,
  output logic [7:0] software_interrupt_opcode,
  output logic [15:0] break_vector,
  output logic break_state,
  output logic timer_stop,
  output logic watchdog_disable,
  output logic status_clear_enable,
  output logic irq
);

  abu_pkg::abu_state_t q;
  abu_pkg::abu_state_t d;
  logic match;
  logic wr_phase;
  logic [7:0] wbyte;
  logic addr_hit;
  logic sw_force;
  logic enter;
  logic addr_written;

  function automatic logic [31:0] read_word(input abu_pkg::abu_state_t s, input logic [4:0] a,
                                            input logic emu);
    logic [31:0] r;
    r = 32'h0000_0000;
    case (a)
      abu_pkg::ABU_OFS_STATUS_CONTROL: begin
        r[abu_pkg::ABU_BIT_BRK_ENABLE] = s.brk_enable_bit;
        r[abu_pkg::ABU_BIT_BREAK_ACTIVE] = s.break_active_bit;
      end
      abu_pkg::ABU_OFS_ADDRESS_HIGH: r[7:0] = s.break_address_high;
      abu_pkg::ABU_OFS_ADDRESS_LOW: r[7:0] = s.break_address_low;
      abu_pkg::ABU_OFS_WAIT_EXIT_STATUS: begin
        r[abu_pkg::ABU_BIT_WAIT_EXIT] = s.wait_exit_by_break_flag & emu;
      end
      abu_pkg::ABU_OFS_FLAG_CLEAR_CONTROL: begin
        r[abu_pkg::ABU_BIT_FLAG_CLEAR] = s.flag_clear_in_break_enable;
      end
      abu_pkg::ABU_OFS_IRQ_STATUS: r[abu_pkg::ABU_IRQ_WIDTH-1:0] = s.irq_status;
      abu_pkg::ABU_OFS_IRQ_MASK: r[abu_pkg::ABU_IRQ_WIDTH-1:0] = s.irq_mask;
      default: r = 32'h0000_0000;
    endcase
    return r;
  endfunction : read_word

  // Full 16-bit comparison of program counter fetches only.
  assign addr_hit = cpu_pc_fetch && (cpu_addr == {q.break_address_high, q.break_address_low});
  assign match = q.brk_enable_bit && addr_hit && !low_power_mode && !q.rearm_block &&
                 (q.fsm == abu_pkg::ABU_IDLE);
  assign wr_phase = q.ap_valid && q.ap_write;
  assign wbyte = hwdata[7:0];
  assign sw_force = wr_phase && (q.ap_addr == abu_pkg::ABU_OFS_STATUS_CONTROL) &&
                    wbyte[abu_pkg::ABU_BIT_BREAK_ACTIVE] && (q.fsm == abu_pkg::ABU_IDLE);
  assign addr_written = wr_phase && ((q.ap_addr == abu_pkg::ABU_OFS_ADDRESS_HIGH) ||
                                     (q.ap_addr == abu_pkg::ABU_OFS_ADDRESS_LOW));
  assign enter = (match && cpu_opcode_fetch) ||
                 ((q.fsm == abu_pkg::ABU_PENDING) && cpu_instr_boundary);

  always_comb begin
    d = q;
    d.inject = 1'b0;
    d.tv_s1 = test_voltage_level;
    d.tv_s2 = q.tv_s1;
    d.tv_s3 = q.tv_s2;
    if (q.tv_s2 == q.tv_s3) begin
      d.tv_level = q.tv_s3;
    end
    d.ap_valid = hsel && htrans[1] && hready;
    d.ap_write = hwrite;
    d.ap_addr = haddr[4:0];
    if (hsel && htrans[1] && hready && !hwrite) begin
      d.rdata = read_word(q, haddr[4:0], emulation_mode);
    end
    if (wr_phase) begin
      case (q.ap_addr)
        abu_pkg::ABU_OFS_STATUS_CONTROL: begin
          d.brk_enable_bit = wbyte[abu_pkg::ABU_BIT_BRK_ENABLE];
          d.break_active_bit = wbyte[abu_pkg::ABU_BIT_BREAK_ACTIVE];
        end
        abu_pkg::ABU_OFS_ADDRESS_HIGH: begin
          d.break_address_high = wbyte;
          d.rearm_block = 1'b0;
        end
        abu_pkg::ABU_OFS_ADDRESS_LOW: begin
          d.break_address_low = wbyte;
          d.rearm_block = 1'b0;
        end
        abu_pkg::ABU_OFS_WAIT_EXIT_STATUS: begin
          if (!wbyte[abu_pkg::ABU_BIT_WAIT_EXIT]) begin
            d.wait_exit_by_break_flag = 1'b0;
          end
        end
        abu_pkg::ABU_OFS_FLAG_CLEAR_CONTROL: begin
          d.flag_clear_in_break_enable = wbyte[abu_pkg::ABU_BIT_FLAG_CLEAR];
        end
        abu_pkg::ABU_OFS_IRQ_STATUS: begin
          d.irq_status = q.irq_status & ~hwdata[abu_pkg::ABU_IRQ_WIDTH-1:0];
        end
        abu_pkg::ABU_OFS_IRQ_MASK: d.irq_mask = hwdata[abu_pkg::ABU_IRQ_WIDTH-1:0];
        default: begin
        end
      endcase
    end
    // Hardware events come after the bus writes so that a set beats a clear.
    case (q.fsm)
      abu_pkg::ABU_IDLE: begin
        if (match) begin
          d.break_active_bit = 1'b1;
          d.rearm_block = 1'b1;
          if (!cpu_opcode_fetch) begin
            d.fsm = abu_pkg::ABU_PENDING;
          end
        end else if (sw_force) begin
          d.fsm = abu_pkg::ABU_PENDING;
        end
      end
      abu_pkg::ABU_PENDING: begin
      end
      abu_pkg::ABU_ACTIVE: begin
        if (cpu_rti_done) begin
          d.fsm = abu_pkg::ABU_IDLE;
        end
      end
      default: d.fsm = abu_pkg::ABU_IDLE;
    endcase
    if (enter) begin
      d.fsm = abu_pkg::ABU_ACTIVE;
      d.inject = 1'b1;
      d.vector = monitor_mode ? abu_pkg::ABU_VECTOR_MONITOR : abu_pkg::ABU_VECTOR_NORMAL;
      d.irq_status[abu_pkg::ABU_IRQ_BREAK_ENTRY] = 1'b1;
      if (wait_mode) begin
        d.wait_exit_by_break_flag = 1'b1;
        d.irq_status[abu_pkg::ABU_IRQ_WAIT_EXIT] = 1'b1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q.fsm <= abu_pkg::ABU_IDLE;
      q.brk_enable_bit <= 1'b0;
      q.break_active_bit <= 1'b0;
      q.break_address_high <= abu_pkg::ABU_RST_BYTE;
      q.break_address_low <= abu_pkg::ABU_RST_BYTE;
      q.rearm_block <= 1'b0;
      q.flag_clear_in_break_enable <= 1'b0;
      q.wait_exit_by_break_flag <= 1'b0;
      q.irq_status <= '0;
      q.irq_mask <= '0;
      q.tv_s1 <= 1'b0;
      q.tv_s2 <= 1'b0;
      q.tv_s3 <= 1'b0;
      q.tv_level <= 1'b0;
      q.ap_valid <= 1'b0;
      q.ap_write <= 1'b0;
      q.ap_addr <= 5'h00;
      q.rdata <= 32'h0000_0000;
      q.inject <= 1'b0;
      q.vector <= abu_pkg::ABU_VECTOR_NORMAL;
    end else if (clk_en) begin
      q <= d;
    end
  end

  assign hreadyout = clk_en;
  assign hresp = 1'b0;
  assign hrdata = q.rdata;
  assign breakpoint_request = q.inject;
  assign software_interrupt_opcode = SOFTWARE_INTERRUPT_OPCODE;
  assign break_vector = q.vector;
  assign break_state = (q.fsm == abu_pkg::ABU_ACTIVE);
  assign timer_stop = (q.fsm == abu_pkg::ABU_ACTIVE);
  assign watchdog_disable = (q.fsm == abu_pkg::ABU_ACTIVE) && q.tv_level;
  assign status_clear_enable = (q.fsm != abu_pkg::ABU_ACTIVE) || q.flag_clear_in_break_enable;
  assign irq = |(q.irq_status & q.irq_mask);

  default clocking cb @(posedge hclk iff clk_en);
  endclocking
  default disable iff (!hresetn);

  logic quiet_bus;
  assign quiet_bus = !wr_phase;

  sequence operand_hit_s;
    match && !cpu_opcode_fetch;
  endsequence

  sequence boundary_take_s;
    (q.fsm == abu_pkg::ABU_PENDING) && cpu_instr_boundary;
  endsequence

  enable_gate_a: assert property ((q.fsm == abu_pkg::ABU_IDLE) && !q.brk_enable_bit && quiet_bus
    |=> (q.fsm == abu_pkg::ABU_IDLE) && !breakpoint_request)
    else $error("break taken with enable clear");

  opcode_take_a: assert property (match && cpu_opcode_fetch
    |=> breakpoint_request && break_state)
    else $error("opcode match did not inject at once");

  vector_sel_a: assert property (enter
    |=> break_vector == ($past(monitor_mode) ? abu_pkg::ABU_VECTOR_MONITOR :
                         abu_pkg::ABU_VECTOR_NORMAL))
    else $error("wrong break vector");

  operand_wait_a: assert property (operand_hit_s ##[1:16] boundary_take_s
    |=> breakpoint_request && timer_stop)
    else $error("operand match not taken at boundary");

  pending_hold_a: assert property ((q.fsm == abu_pkg::ABU_PENDING) && !cpu_instr_boundary
    |=> !breakpoint_request && (q.fsm == abu_pkg::ABU_PENDING))
    else $error("break taken before boundary");

  sw_force_a: assert property (sw_force && !enter
    |=> (q.fsm == abu_pkg::ABU_PENDING) && q.break_active_bit)
    else $error("forced break not pending");

  active_set_a: assert property (match |=> q.break_active_bit && q.rearm_block)
    else $error("active bit not set on match");

  rearm_block_a: assert property (q.rearm_block && addr_hit && q.brk_enable_bit &&
    (q.fsm == abu_pkg::ABU_IDLE) && quiet_bus |=> (q.fsm == abu_pkg::ABU_IDLE))
    else $error("unchanged address broke again");

  rearm_new_a: assert property (addr_written && (q.fsm != abu_pkg::ABU_IDLE)
    |=> !q.rearm_block)
    else $error("new address did not rearm");

  low_power_a: assert property (low_power_mode && (q.fsm == abu_pkg::ABU_IDLE) && quiet_bus
    |=> (q.fsm == abu_pkg::ABU_IDLE))
    else $error("break triggered in low power mode");

  timer_stop_a: assert property (breakpoint_request |-> timer_stop && break_state)
    else $error("timer not stopped at break entry");

  watchdog_a: assert property (watchdog_disable |-> timer_stop && q.tv_level)
    else $error("watchdog disabled outside break or without test level");

  flag_clear_a: assert property (timer_stop && !q.flag_clear_in_break_enable
    |-> !status_clear_enable)
    else $error("status clear allowed in break without enable");

  rti_end_a: assert property (break_state && cpu_rti_done && !enter
    |=> !break_state && !timer_stop)
    else $error("break did not end on return");

  // Synchroniser, register, interrupt, pending-entry and clock-enable checks.
  sync_agree_a: assert property (q.tv_level != $past(q.tv_level)
    |-> $past(q.tv_s2) == $past(q.tv_s3))
    else $error("test level accepted before flops agreed");

  irq_level_a: assert property (q.irq_status[abu_pkg::ABU_IRQ_BREAK_ENTRY] &&
    q.irq_mask[abu_pkg::ABU_IRQ_BREAK_ENTRY] |-> irq)
    else $error("unmasked break entry without interrupt");

  entry_irq_a: assert property (enter
    |=> q.irq_status[abu_pkg::ABU_IRQ_BREAK_ENTRY])
    else $error("break entry not flagged");

  entry_status_a: assert property (enter && wait_mode
    |=> q.wait_exit_by_break_flag)
    else $error("wait exit by break not flagged");

  wait_clear_a: assert property (wr_phase && !enter &&
    (q.ap_addr == abu_pkg::ABU_OFS_WAIT_EXIT_STATUS) && !wbyte[abu_pkg::ABU_BIT_WAIT_EXIT]
    |=> !q.wait_exit_by_break_flag)
    else $error("wait exit flag not cleared");

  pending_enter_a: assert property (boundary_take_s
    |=> breakpoint_request && break_state)
    else $error("pending break not taken at boundary");

  active_clear_a: assert property (wr_phase && !match &&
    (q.ap_addr == abu_pkg::ABU_OFS_STATUS_CONTROL) && !wbyte[abu_pkg::ABU_BIT_BREAK_ACTIVE]
    |=> !q.break_active_bit)
    else $error("active bit not cleared by software");

  enable_write_a: assert property (wr_phase &&
    (q.ap_addr == abu_pkg::ABU_OFS_STATUS_CONTROL)
    |=> q.brk_enable_bit == $past(wbyte[abu_pkg::ABU_BIT_BRK_ENABLE]))
    else $error("enable bit not written");

  addr_write_a: assert property (wr_phase &&
    (q.ap_addr == abu_pkg::ABU_OFS_ADDRESS_LOW)
    |=> q.break_address_low == $past(wbyte))
    else $error("address low byte not written");

  read_high_a: assert property (hsel && htrans[1] && hready && !hwrite &&
    (haddr[4:0] == abu_pkg::ABU_OFS_ADDRESS_HIGH)
    |=> hrdata == {24'h000000, $past(q.break_address_high)})
    else $error("address high byte read back wrong");

  status_enable_a: assert property (q.flag_clear_in_break_enable
    |-> status_clear_enable)
    else $error("status clear blocked with enable set");

  freeze_hold_a: assert property (@(posedge hclk) !clk_en |=> q == $past(q))
    else $error("state moved while clock enable low");

  freeze_ready_a: assert property (@(posedge hclk) !clk_en |-> !hreadyout)
    else $error("bus ready while clock enable low");

endmodule : abu_address_breakpoint_unit

//--- verif/abu_cpu_model.sv
// CPU core model facing the address breakpoint unit.
`timescale 1ns/1ps
module abu_cpu_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic breakpoint_request,
  input wire logic [15:0] break_vector,
  output logic [15:0] cpu_addr,
  output logic cpu_pc_fetch,
  output logic cpu_opcode_fetch,
  output logic cpu_instr_boundary,
  output logic cpu_rti_done,
  output logic [7:0] req_count,
  output logic [15:0] seen_vector
);
  initial begin
    cpu_addr = 16'h5a5a;
    cpu_pc_fetch = 1'b0;
    cpu_opcode_fetch = 1'b0;
    cpu_instr_boundary = 1'b0;
    cpu_rti_done = 1'b0;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_count <= 8'h00;
      seen_vector <= 16'h0000;
    end else if (breakpoint_request) begin
      req_count <= req_count + 8'h01;
      seen_vector <= break_vector;
    end
  end
  // One fetch cycle; afterwards the bus shows changed, meaningless contents.
  task automatic fetch(input logic [15:0] a, input logic op, input logic pc);
    @(posedge hclk);
    cpu_addr <= a;
    cpu_pc_fetch <= pc;
    cpu_opcode_fetch <= op;
    @(posedge hclk);
    cpu_addr <= ~a;
    cpu_pc_fetch <= 1'b0;
    cpu_opcode_fetch <= ~op;
  endtask : fetch
  // One instruction boundary, or one return from the break routine.
  task automatic pulse(input logic return_from_interrupt_opcode);
    @(posedge hclk);
    cpu_instr_boundary <= ~return_from_interrupt_opcode;
    cpu_rti_done <= return_from_interrupt_opcode;
    @(posedge hclk);
    cpu_instr_boundary <= 1'b0;
    cpu_rti_done <= 1'b0;
  endtask : pulse
endmodule : abu_cpu_model

//--- verif/tb_top.sv
// Self-checking testbench of the address breakpoint unit.
`timescale 1ns/1ps
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin bad_count++; \
  $display("ERROR %s expected %h seen %h", n, e, s); end end
module tb_top;
  localparam logic [4:0] SC = abu_pkg::ABU_OFS_STATUS_CONTROL;
  localparam logic [4:0] AH = abu_pkg::ABU_OFS_ADDRESS_HIGH;
  localparam logic [4:0] AL = abu_pkg::ABU_OFS_ADDRESS_LOW;
  localparam logic [4:0] WX = abu_pkg::ABU_OFS_WAIT_EXIT_STATUS;
  localparam logic [4:0] FC = abu_pkg::ABU_OFS_FLAG_CLEAR_CONTROL;
  localparam logic [4:0] IS = abu_pkg::ABU_OFS_IRQ_STATUS;
  localparam logic [4:0] IM = abu_pkg::ABU_OFS_IRQ_MASK;
  int bad_count = 0;
  int total_checks = 0;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, breakpoint_request, break_state, timer_stop, watchdog_disable, irq;
  logic [31:0] hrdata;
  logic [15:0] cpu_addr, break_vector, seen_vector;
  logic cpu_pc_fetch, cpu_opcode_fetch, cpu_instr_boundary, cpu_rti_done, status_clear_enable;
  logic [7:0] software_interrupt_opcode, req_count;
  logic lpm = 1'b0;
  logic wmode = 1'b0;
  logic mon = 1'b0;
  logic emu = 1'b0;
  logic tv = 1'b0;
  logic clk_en = 1'b1;
  logic hsel = 1'b1;
  always #2.5 hclk = ~hclk;
  abu_address_breakpoint_unit u_abu_address_breakpoint_unit (.hclk(hclk), .hresetn(hresetn),
    .clk_en(clk_en), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .cpu_addr(cpu_addr), .cpu_pc_fetch(cpu_pc_fetch),
    .cpu_opcode_fetch(cpu_opcode_fetch), .cpu_instr_boundary(cpu_instr_boundary),
    .cpu_rti_done(cpu_rti_done), .low_power_mode(lpm), .wait_mode(wmode), .monitor_mode(mon),
    .emulation_mode(emu), .test_voltage_level(tv), .breakpoint_request(breakpoint_request),
    .software_interrupt_opcode(software_interrupt_opcode), .break_vector(break_vector),
    .break_state(break_state), .timer_stop(timer_stop), .watchdog_disable(watchdog_disable),
    .status_clear_enable(status_clear_enable), .irq(irq));
  abu_cpu_model u_abu_cpu_model (.hclk(hclk), .hresetn(hresetn),
    .breakpoint_request(breakpoint_request), .break_vector(break_vector), .cpu_addr(cpu_addr),
    .cpu_pc_fetch(cpu_pc_fetch), .cpu_opcode_fetch(cpu_opcode_fetch),
    .cpu_instr_boundary(cpu_instr_boundary), .cpu_rti_done(cpu_rti_done),
    .req_count(req_count), .seen_vector(seen_vector));
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d,
                     output logic [31:0] rd);
    @(posedge hclk);
    htrans <= 2'h2;
    haddr <= {27'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    #1;
  endtask : bus
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [31:0] rd;
    bus(1'b1, a, d, rd);
  endtask : wr
  task automatic rchk(input logic [4:0] a, input logic [31:0] e);
    logic [31:0] rd;
    bus(1'b0, a, 8'h00, rd);
    `CHK("register", e, rd)
  endtask : rchk
  task automatic settle(input int n);
    repeat (n) @(posedge hclk);
    #1;
  endtask : settle
  task automatic t_reset;
    rchk(SC, 32'h0);
    rchk(AH, 32'h0);
    rchk(AL, 32'h0);
    rchk(FC, 32'h0);
    rchk(5'h1c, 32'h0);
    `CHK("vector", 16'hfffc, break_vector)
    `CHK("opcode", 8'h00, software_interrupt_opcode)
    `CHK("response", 1'b0, hresp)
    wr(AH, 8'h12);
    wr(AL, 8'h34);
    rchk(AH, 32'h12);
  endtask : t_reset
  task automatic t_opcode;
    wr(IM, 8'h03);
    wr(SC, 8'h80);
    wmode <= 1'b1;
    emu <= 1'b1;
    tv <= 1'b1;
    // The breakpoint sits on an opcode address.
    u_abu_cpu_model.fetch(16'h1234, 1'b1, 1'b1);
    settle(1);
    `CHK("requests", 8'h01, req_count)
    `CHK("vector", 16'hfffc, seen_vector)
    `CHK("timer", 1'b1, timer_stop)
    `CHK("clear enable", 1'b0, status_clear_enable)
    settle(5);
    `CHK("watchdog", 1'b1, watchdog_disable)
    rchk(SC, 32'hc0);
    rchk(WX, 32'h02);
    wr(WX, 8'h00);
    rchk(WX, 32'h0);
    rchk(IS, 32'h03);
    `CHK("irq", 1'b1, irq)
    wr(FC, 8'h80);
    `CHK("clear enable", 1'b1, status_clear_enable)
    wr(IM, 8'h00);
    `CHK("irq", 1'b0, irq)
    wr(IS, 8'h03);
    rchk(IS, 32'h0);
    wr(SC, 8'h80);
    u_abu_cpu_model.pulse(1'b1);
    #1;
    `CHK("break state", 1'b0, break_state)
    wmode <= 1'b0;
    emu <= 1'b0;
    tv <= 1'b0;
  endtask : t_opcode
  task automatic t_rearm;
    u_abu_cpu_model.fetch(16'h1234, 1'b1, 1'b1);
    settle(2);
    `CHK("requests", 8'h01, req_count)
    wr(AL, 8'h56);
    u_abu_cpu_model.fetch(16'h1256, 1'b1, 1'b1);
    settle(1);
    `CHK("requests", 8'h02, req_count)
    wr(AL, 8'h78);
    wr(SC, 8'h80);
    u_abu_cpu_model.pulse(1'b1);
  endtask : t_rearm
  task automatic t_operand;
    mon <= 1'b1;
    wr(AL, 8'h78);
    u_abu_cpu_model.fetch(16'h1278, 1'b0, 1'b1);
    settle(3);
    `CHK("requests", 8'h02, req_count)
    u_abu_cpu_model.pulse(1'b0);
    settle(2);
    `CHK("requests", 8'h03, req_count)
    `CHK("vector", 16'hfefc, seen_vector)
    wr(SC, 8'h80);
    u_abu_cpu_model.pulse(1'b1);
    mon <= 1'b0;
  endtask : t_operand
  task automatic t_force;
    wr(SC, 8'h00);
    wr(AL, 8'h9a);
    u_abu_cpu_model.fetch(16'h129a, 1'b1, 1'b1);
    settle(2);
    `CHK("requests", 8'h03, req_count)
    wr(SC, 8'h40);
    u_abu_cpu_model.pulse(1'b0);
    settle(2);
    `CHK("requests", 8'h04, req_count)
    `CHK("watchdog", 1'b0, watchdog_disable)
    wr(SC, 8'h00);
    u_abu_cpu_model.pulse(1'b1);
  endtask : t_force
  task automatic t_freeze;
    wr(SC, 8'h80);
    clk_en <= 1'b0;
    u_abu_cpu_model.fetch(16'h129a, 1'b1, 1'b1);
    settle(1);
    `CHK("ready", 1'b0, hreadyout)
    `CHK("requests", 8'h04, req_count)
    clk_en <= 1'b1;
    hsel <= 1'b0;
    wr(AL, 8'h11);
    hsel <= 1'b1;
    rchk(AL, 32'h9a);
  endtask : t_freeze
  task automatic t_quiet;
    wr(SC, 8'h80);
    wr(AL, 8'hbc);
    lpm <= 1'b1;
    u_abu_cpu_model.fetch(16'h12bc, 1'b1, 1'b1);
    settle(2);
    `CHK("requests", 8'h04, req_count)
    lpm <= 1'b0;
    u_abu_cpu_model.fetch(16'h12bc, 1'b1, 1'b0);
    settle(2);
    `CHK("requests", 8'h04, req_count)
    u_abu_cpu_model.fetch(16'h12bc, 1'b1, 1'b1);
    settle(1);
    `CHK("requests", 8'h05, req_count)
  endtask : t_quiet
  task automatic conclude;
    if (bad_count == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : conclude
  initial begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_opcode();
    t_rearm();
    t_operand();
    t_force();
    t_freeze();
    t_quiet();
    conclude();
  end
  initial begin
    #200000;
    bad_count++;
    conclude();
  end
endmodule : tb_top
